// [common/ccrs_defines.vh]
// Constants for the core register set: field positions, reset values and op codes.
// Assumes inclusion by bare name from the design files.
`ifndef CCRS_DEFINES_VH
`define CCRS_DEFINES_VH
`define CCRS_CC_C        0
`define CCRS_CC_Z        1
`define CCRS_CC_N        2
`define CCRS_CC_PL       3
`define CCRS_CC_H        4
`define CCRS_CC_PH       5
`define CCRS_CC_RST      8'hFA
`define CCRS_CC_ONES     8'hC0
`define CCRS_SP_RST      16'h01FF
`define CCRS_SP_HI       8'h01
`define CCRS_PC_RST      16'h0000
`define CCRS_OP_NOP      4'h0
`define CCRS_OP_ADD      4'h1
`define CCRS_OP_ADC      4'h2
`define CCRS_OP_SUB      4'h3
`define CCRS_OP_LOGIC    4'h4
`define CCRS_OP_SHIFT    4'h5
`define CCRS_OP_BTJ      4'h6
`define CCRS_OP_SCF      4'h7
`define CCRS_OP_RCF      4'h8
`define CCRS_OP_PRIO     4'h9
`define CCRS_OP_CCLOAD   4'hA
`define CCRS_DST_A       2'h0
`define CCRS_DST_X       2'h1
`define CCRS_DST_Y       2'h2
`define CCRS_DST_NONE    2'h3
`define CCRS_SEL_PCL     3'h0
`define CCRS_SEL_PCH     3'h1
`define CCRS_SEL_X       3'h2
`define CCRS_SEL_A       3'h3
`define CCRS_SEL_CC      3'h4
`endif

// [src/ccrs_alu.v]
// Eight-bit adder and flag generator for the core register set.
// Assumes operands and carry in come from logic on core_clk; purely combinational.
`timescale 1ns/1ns
module ccrs_alu #(
    parameter W = 8
) (
    input  wire [3:0]   op,
    input  wire [W-1:0] opa,
    input  wire [W-1:0] opb,
    input  wire         cin,
    output reg  [W-1:0] res,
    output reg          half,
    output reg          carry
);
`include "ccrs_defines.vh"
    reg [W:0]   sum;
    reg [4:0]   low;
    always @* begin
        sum   = {(W+1){1'b0}};
        low   = 5'h00;
        res   = opb;
        half  = 1'b0;
        carry = 1'b0;
        case (op)
            `CCRS_OP_ADD, `CCRS_OP_ADC: begin
                sum   = {1'b0, opa} + {1'b0, opb} + {{W{1'b0}}, (op == `CCRS_OP_ADC) & cin};
                low   = {1'b0, opa[3:0]} + {1'b0, opb[3:0]}
                        + {4'h0, (op == `CCRS_OP_ADC) & cin};
                res   = sum[W-1:0];
                half  = low[4];
                carry = sum[W];
            end
            `CCRS_OP_SUB: begin
                sum   = {1'b0, opa} - {1'b0, opb};
                res   = sum[W-1:0];
                carry = sum[W];
            end
            `CCRS_OP_SHIFT: begin
                res   = {opa[W-2:0], cin};
                carry = opa[W-1];
            end
            default: begin
                res   = opb;
            end
        endcase
    end
endmodule

// [src/ccrs_core_regs.v]
// Core register set: accumulator, two index registers, program counter,
// condition code register and stack pointer with context push and pop.
// Assumes the instruction sequencer drives the strobes on core_clk, one op per enabled cycle.
// Summary of operation
// - Add sets half carry from bit 3.
// - Negative flag copies result bit seven.
// - Zero flag set when result is zero.
// - Carry from arithmetic, bit test, shift, rotate.
// - Set and clear carry ops; jumps test carry.
// - Priority encoded in bits five and three.
// - Interrupt entry loads priority from registers.
// - Mask, return, halt, wait, pop modify priority.
// - Eight-bit flags register, reset 111x1xxx, stackable.
// - Pointer decrements after push, increments before pop.
// - Upper byte fixed; reset and reload give 01FF.
// - Pointer wraps silently at both limits.
// - Call pushes two bytes, interrupt five, low first.
// - Second index register not saved on interrupt.
// - Sixteen-bit program counter, low and high bytes.
// - Accumulator and two index registers, eight bits.
// - Load reads and writes pointer low byte.
`timescale 1ns/1ns
module ccrs_core_regs #(
    parameter W = 8
) (
    input  wire         core_clk,
    input  wire         reset_n,
    input  wire         clk_en,
    input  wire [3:0]   alu_op,
    input  wire [1:0]   alu_dst,
    input  wire [W-1:0] alu_b,
    input  wire [1:0]   prio_val,
    input  wire         reload_stack_top_op,
    input  wire         sp_low_wr,
    input  wire [7:0]   sp_low_wdata,
    input  wire         push_op,
    input  wire         pop_op,
    input  wire [7:0]   push_data,
    input  wire [7:0]   pop_data,
    input  wire [2:0]   pop_sel,
    input  wire         call_op,
    input  wire         irq_entry_op,
    input  wire [1:0]   sw_priority_regs,
    input  wire         pc_load,
    input  wire [15:0]  pc_target,
    input  wire         pc_incr,
    input  wire         jmp_on_carry,
    input  wire         jmp_on_no_carry,
    input  wire [15:0]  jmp_target,
    output reg  [7:0]   acc_ff,
    output reg  [7:0]   index_x_ff,
    output reg  [7:0]   index_y_ff,
    output reg  [15:0]  program_counter_ff,
    output reg  [7:0]   condition_code_register_ff,
    output reg  [15:0]  stack_pointer_ff,
    output reg  [7:0]   stack_wdata_ff,
    output reg          stack_we_ff,
    output reg          busy_ff
);
`include "ccrs_defines.vh"
    localparam ST_IDLE = 2'h0;
    localparam ST_PUSH = 2'h1;

    wire [7:0]  alu_a;
    wire [7:0]  alu_res;
    wire        alu_half;
    wire        alu_carry;
    reg  [1:0]  state_ff;
    reg  [2:0]  cnt_ff;
    reg  [2:0]  total_ff;
    reg  [39:0] ctx_ff;
    reg  [7:0]  nxt_cc;
    reg  [7:0]  sp_lo_ff;
    reg  [7:0]  cc_now;

    assign alu_a = (alu_dst == `CCRS_DST_X) ? index_x_ff :
                   (alu_dst == `CCRS_DST_Y) ? index_y_ff : acc_ff;

    ccrs_alu #(.W(8)) u_alu (
        .op    (alu_op),
        .opa   (alu_a),
        .opb   (alu_b),
        .cin   (condition_code_register_ff[`CCRS_CC_C]),
        .res   (alu_res),
        .half  (alu_half),
        .carry (alu_carry)
    );

    always @* begin
        cc_now = condition_code_register_ff;
        nxt_cc = condition_code_register_ff;
        case (alu_op)
            `CCRS_OP_ADD, `CCRS_OP_ADC: begin
                nxt_cc[`CCRS_CC_H] = alu_half;
                nxt_cc[`CCRS_CC_C] = alu_carry;
            end
            `CCRS_OP_SUB, `CCRS_OP_SHIFT: begin
                nxt_cc[`CCRS_CC_C] = alu_carry;
            end
            `CCRS_OP_BTJ: begin
                nxt_cc[`CCRS_CC_C] = alu_b[0];
            end
            `CCRS_OP_SCF: nxt_cc[`CCRS_CC_C] = 1'b1;
            `CCRS_OP_RCF: nxt_cc[`CCRS_CC_C] = 1'b0;
            `CCRS_OP_PRIO: begin
                // Mask, unmask, return, halt, wait set priority.
                nxt_cc[`CCRS_CC_PH] = prio_val[1];
                nxt_cc[`CCRS_CC_PL] = prio_val[0];
            end
            `CCRS_OP_CCLOAD: nxt_cc = alu_b;
            default: nxt_cc = condition_code_register_ff;
        endcase
        if (alu_op >= `CCRS_OP_ADD && alu_op <= `CCRS_OP_SHIFT) begin
            nxt_cc[`CCRS_CC_N] = alu_res[7];
            nxt_cc[`CCRS_CC_Z] = (alu_res == 8'h00);
        end
        if (pop_op && pop_sel == `CCRS_SEL_CC) begin
            nxt_cc = pop_data;
        end
        if (irq_entry_op) begin
            // Priority from the software priority registers.
            nxt_cc[`CCRS_CC_PH] = sw_priority_regs[1];
            nxt_cc[`CCRS_CC_PL] = sw_priority_regs[0];
        end
        nxt_cc = nxt_cc | `CCRS_CC_ONES;
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_ff                     <= 8'h00;
            index_x_ff                 <= 8'h00;
            index_y_ff                 <= 8'h00;
            program_counter_ff         <= `CCRS_PC_RST;
            // Undefined reset bits load H and Z as one, N and C as zero.
            condition_code_register_ff <= `CCRS_CC_RST;
            sp_lo_ff                   <= 8'hFF;
            stack_pointer_ff           <= `CCRS_SP_RST;
            stack_wdata_ff             <= 8'h00;
            stack_we_ff                <= 1'b0;
            busy_ff                    <= 1'b0;
            state_ff                   <= ST_IDLE;
            cnt_ff                     <= 3'h0;
            total_ff                   <= 3'h0;
            ctx_ff                     <= 40'h00_0000_0000;
        end else if (clk_en) begin
            stack_we_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    condition_code_register_ff <= nxt_cc;
                    // Result lands in the selected register.
                    if (alu_op != `CCRS_OP_NOP && alu_op <= `CCRS_OP_SHIFT) begin
                        case (alu_dst)
                            `CCRS_DST_A: acc_ff     <= alu_res;
                            `CCRS_DST_X: index_x_ff <= alu_res;
                            `CCRS_DST_Y: index_y_ff <= alu_res;
                            default:     acc_ff     <= acc_ff;
                        endcase
                    end
                    if (pc_load) begin
                        program_counter_ff <= pc_target;
                    end else if ((jmp_on_carry && condition_code_register_ff[`CCRS_CC_C])
                            || (jmp_on_no_carry && !condition_code_register_ff[`CCRS_CC_C])) begin
                        program_counter_ff <= jmp_target;
                    end else if (pc_incr) begin
                        program_counter_ff <= program_counter_ff + 16'h0001;
                    end
                    if (reload_stack_top_op) begin
                        sp_lo_ff <= 8'hFF;
                    end else if (sp_low_wr) begin
                        sp_lo_ff <= sp_low_wdata;
                    end else if (push_op) begin
                        stack_wdata_ff <= push_data;
                        stack_we_ff    <= 1'b1;
                        sp_lo_ff       <= sp_lo_ff - 8'h01;
                    end else if (pop_op) begin
                        sp_lo_ff <= sp_lo_ff + 8'h01;
                        case (pop_sel)
                            `CCRS_SEL_PCL: program_counter_ff[7:0]  <= pop_data;
                            `CCRS_SEL_PCH: program_counter_ff[15:8] <= pop_data;
                            `CCRS_SEL_X:   index_x_ff               <= pop_data;
                            `CCRS_SEL_A:   acc_ff                   <= pop_data;
                            default:       index_y_ff               <= index_y_ff;
                        endcase
                    end else if (irq_entry_op || call_op) begin
                        // Low PC byte first; five bytes or two.
                        ctx_ff   <= {condition_code_register_ff, acc_ff, index_x_ff,
                                     program_counter_ff[15:8], program_counter_ff[7:0]};
                        total_ff <= irq_entry_op ? 3'h5 : 3'h2;
                        cnt_ff   <= 3'h0;
                        busy_ff  <= 1'b1;
                        state_ff <= ST_PUSH;
                        if (pc_load) begin
                            program_counter_ff <= pc_target;
                        end
                    end
                end
                ST_PUSH: begin
                    stack_wdata_ff <= ctx_ff[7:0];
                    stack_we_ff    <= 1'b1;
                    ctx_ff         <= {8'h00, ctx_ff[39:8]};
                    sp_lo_ff       <= sp_lo_ff - 8'h01;
                    cnt_ff         <= cnt_ff + 3'h1;
                    if (cnt_ff + 3'h1 == total_ff) begin
                        busy_ff  <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
            stack_pointer_ff <= {`CCRS_SP_HI, sp_lo_ff};
        end
    end
endmodule

// [tb/ccrs_properties.sv]
// Concurrent checks on the ports of the core register set.
// Assumes it is bound onto ccrs_core_regs, which has a single clock domain.
`timescale 1ns/1ns
module ccrs_properties (
    input wire        core_clk,
    input wire        reset_n,
    input wire        clk_en,
    input wire [3:0]  alu_op,
    input wire [1:0]  alu_dst,
    input wire        reload_stack_top_op,
    input wire        sp_low_wr,
    input wire        push_op,
    input wire        pop_op,
    input wire [7:0]  push_data,
    input wire        call_op,
    input wire        irq_entry_op,
    input wire [1:0]  sw_priority_regs,
    input wire [7:0]  acc_ff,
    input wire [7:0]  index_y_ff,
    input wire [7:0]  condition_code_register_ff,
    input wire [15:0] stack_pointer_ff,
    input wire [7:0]  stack_wdata_ff,
    input wire        stack_we_ff,
    input wire        busy_ff
);
    // Strobes rank reload, low write, push, pop, then interrupt over call; lower ones lose.
    wire       go     = clk_en & ~busy_ff;
    wire       push_go = go & push_op & ~reload_stack_top_op & ~sp_low_wr;
    wire       irq_go = go & irq_entry_op & ~(reload_stack_top_op | sp_low_wr | push_op
                        | pop_op | call_op);
    wire [7:0] cc     = condition_code_register_ff;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    top_bits_a: assert property (cc[7:6] == 2'b11)
        else $error("flag bits 7 and 6 not one");
    sp_page_a: assert property (stack_pointer_ff[15:8] == 8'h01)
        else $error("stack page moved");
    set_carry_a: assert property (go && alu_op == 4'h7 && !pop_op |=> cc[0])
        else $error("carry not set");
    sign_zero_a: assert property (go && alu_op inside {[4'h1:4'h5]} && alu_dst == 2'h0
        && !pop_op |=> cc[2] == acc_ff[7] && cc[1] == (acc_ff == 8'h00))
        else $error("sign or zero flag wrong");
    prio_load_a: assert property (irq_go |=> {cc[5], cc[3]} == $past(sw_priority_regs))
        else $error("priority not loaded on entry");
    ctx_push_a: assert property (irq_go |=> busy_ff ##1 stack_we_ff [*5] ##1 !stack_we_ff)
        else $error("context push not five bytes");
    y_kept_a: assert property (irq_go |=> $stable(index_y_ff) [*6])
        else $error("second index changed on entry");
    push_data_a: assert property (push_go |=> stack_we_ff && stack_wdata_ff == $past(push_data))
        else $error("push write wrong");
    reload_top_a: assert property (go && reload_stack_top_op |-> ##[1:2] stack_pointer_ff[7:0] == 8'hFF)
        else $error("reload did not reach top");
    cover property (irq_go);
    cover property (push_go);
    cover property (go && reload_stack_top_op);
endmodule
bind ccrs_core_regs ccrs_properties i_props (.*);

// [tb/tb.sv]
// Self-checking bench for the core register set, driving all inputs on the falling edge.
// Assumes ccrs_core_regs and its checker are compiled before this file.
`timescale 1ns/1ns
module tb;
    reg         core_clk, reset_n, clk_en, reload_stack_top_op, sp_low_wr, push_op, pop_op;
    reg         call_op, irq_entry_op, pc_load, pc_incr, jmp_on_carry, jmp_on_no_carry;
    reg  [3:0]  alu_op;
    reg  [1:0]  alu_dst, prio_val, sw_priority_regs;
    reg  [7:0]  alu_b, sp_low_wdata, push_data, pop_data;
    reg  [2:0]  pop_sel;
    reg  [15:0] pc_target, jmp_target;
    wire [7:0]  acc_ff, index_x_ff, index_y_ff, condition_code_register_ff, stack_wdata_ff;
    wire [15:0] program_counter_ff, stack_pointer_ff;
    wire        stack_we_ff, busy_ff;
    integer     error_cnt, checked, cyc, n;
    reg  [39:0] got;
    wire [7:0]  cc = condition_code_register_ff;
    ccrs_core_regs i_dut (.*);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task give_verdict;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string name, input [39:0] exp, input [39:0] act);
        checked = checked + 1;
        if (act !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %s exp %h got %h", name, exp, act);
        end
    endtask
    task alu(input [3:0] o, input [1:0] d, input [7:0] b);
        alu_op = o;
        alu_dst = d;
        alu_b = b;
        @(negedge core_clk);
        alu_op = 4'h0;
        // A nop cycle keeps two calls in a row from assigning alu_op twice in one step.
        @(negedge core_clk);
    endtask
    // Gathers stack writes over eight cycles, newest byte lowest.
    task grab;
        n = 0;
        got = 40'h0;
        repeat (8) begin
            @(negedge core_clk);
            if (stack_we_ff === 1'b1) begin
                got = {got[31:0], stack_wdata_ff};
                n = n + 1;
            end
        end
    endtask
    task t_add;
        alu(4'h1, 2'h0, 8'h0F);
        alu(4'h1, 2'h0, 8'h01);
        chk("half", 1'b1, cc[4]);
        alu(4'h1, 2'h0, 8'hF0);
        chk("hzc", 3'b011, {cc[4], cc[1], cc[0]});
        alu(4'h1, 2'h0, 8'h80);
        chk("nzc", 3'b100, {cc[2], cc[1], cc[0]});
    endtask
    task t_carry;
        alu(4'h7, 2'h3, 8'h00);
        chk("carry set", 1'b1, cc[0]);
        jmp_on_carry = 1'b1;
        jmp_target = 16'h1234;
        @(negedge core_clk);
        alu(4'h8, 2'h3, 8'h00);
        jmp_target = 16'h4321;
        @(negedge core_clk);
        jmp_on_carry = 1'b0;
        chk("carry clr", 1'b0, cc[0]);
        chk("pc", 16'h1234, program_counter_ff);
    endtask
    task t_prio;
        integer i;
        for (i = 0; i < 4; i = i + 1) begin
            prio_val = i[1:0];
            alu(4'h9, 2'h3, 8'h00);
            chk("prio", i[1:0], {cc[5], cc[3]});
        end
    endtask
    task t_irq;
        alu(4'h1, 2'h1, 8'h33);
        sw_priority_regs = 2'b01;
        irq_entry_op = 1'b1;
        @(negedge core_clk);
        irq_entry_op = 1'b0;
        chk("busy", 1'b1, busy_ff);
        grab;
        chk("ctx count", 5, n);
        chk("ctx", 32'h34123380, got[39:8]);
        chk("ctx cc", 8'hE8, got[7:0]);
        chk("irq prio", 2'b01, {cc[5], cc[3]});
        chk("y", 8'h00, index_y_ff);
        chk("sp irq", 16'h01FA, stack_pointer_ff);
    endtask
    task t_stack;
        reload_stack_top_op = 1'b1;
        @(negedge core_clk);
        reload_stack_top_op = 1'b0;
        @(negedge core_clk);
        chk("sp reload", 16'h01FF, stack_pointer_ff);
        sp_low_wr = 1'b1;
        @(negedge core_clk);
        sp_low_wr = 1'b0;
        push_op = 1'b1;
        push_data = 8'h5A;
        @(negedge core_clk);
        push_op = 1'b0;
        chk("push", 9'h15A, {stack_we_ff, stack_wdata_ff});
        repeat (2) @(negedge core_clk);
        chk("sp wrap", 16'h01FF, stack_pointer_ff);
        call_op = 1'b1;
        @(negedge core_clk);
        call_op = 1'b0;
        grab;
        chk("call count", 2, n);
        chk("call bytes", 16'h3412, got[15:0]);
    endtask
    task t_misc;
        alu(4'hA, 2'h3, 8'h00);
        chk("ccload", 8'hC0, cc);
        alu(4'h4, 2'h2, 8'hFE);
        alu(4'h5, 2'h2, 8'h00);
        chk("shift", 10'h3FC, {cc[2], cc[0], index_y_ff});
        alu(4'h2, 2'h0, 8'h7F);
        chk("adc", 3'b111, {cc[4], cc[1], cc[0]});
        alu(4'h3, 2'h0, 8'h01);
        chk("sub", 10'h3FF, {cc[2], cc[0], acc_ff});
        alu(4'h6, 2'h3, 8'h00);
        chk("btj", 1'b0, cc[0]);
        jmp_on_no_carry = 1'b1;
        jmp_target = 16'h2468;
        @(negedge core_clk);
        jmp_on_no_carry = 1'b0;
        chk("pc nc", 16'h2468, program_counter_ff);
        pc_incr = 1'b1;
        @(negedge core_clk);
        chk("pc inc", 16'h2469, program_counter_ff);
        pc_load = 1'b1;
        pc_target = 16'h0100;
        @(negedge core_clk);
        pc_load = 1'b0;
        pc_incr = 1'b0;
        chk("pc load", 16'h0100, program_counter_ff);
        pop_op = 1'b1;
        pop_sel = 3'h0;
        pop_data = 8'h55;
        @(negedge core_clk);
        pop_sel = 3'h1;
        pop_data = 8'hAA;
        @(negedge core_clk);
        pop_sel = 3'h3;
        pop_data = 8'h11;
        @(negedge core_clk);
        pop_sel = 3'h4;
        pop_data = 8'h00;
        @(negedge core_clk);
        pop_op = 1'b0;
        @(negedge core_clk);
        chk("pop pc", 16'hAA55, program_counter_ff);
        chk("pop a", 8'h11, acc_ff);
        chk("pop cc", 8'hC0, cc);
        chk("sp pop", 16'h0101, stack_pointer_ff);
        clk_en = 1'b0;
        alu(4'h4, 2'h0, 8'h99);
        clk_en = 1'b1;
        chk("frozen", 16'h11C0, {acc_ff, cc});
        reset_n = 1'b0;
        @(negedge core_clk);
        reset_n = 1'b1;
        chk("rst regs", 24'h00FA00, {acc_ff, cc, index_y_ff});
        chk("rst sp pc", 32'h01FF0000, {stack_pointer_ff, program_counter_ff});
    endtask
    // The whole run needs about 75 cycles, so 3000 only trips on a hang.
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            give_verdict;
        end
    end
    initial begin
        {reload_stack_top_op, sp_low_wr, push_op, pop_op, call_op, irq_entry_op} = 6'h00;
        {pc_load, pc_incr, jmp_on_carry, jmp_on_no_carry, alu_op, alu_dst} = 10'h000;
        {prio_val, sw_priority_regs, alu_b, sp_low_wdata, push_data, pop_data} = 36'h0;
        {pop_sel, pc_target, jmp_target} = 35'h0;
        {error_cnt, checked, cyc} = 0;
        clk_en = 1'b1;
        reset_n = 1'b0;
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        chk("flags rst", 8'hFA, cc);
        chk("sp rst", 16'h01FF, stack_pointer_ff);
        t_add;
        t_carry;
        t_prio;
        t_irq;
        t_stack;
        t_misc;
        give_verdict;
    end
endmodule
